// ---- hw/ric_regs.sv ----
// APB register bank configuring eight reference input receivers
`include "ric_defines.svh"

module ric_regs #(
  parameter int NUM_PAIRS = 4,   // Receiver pairs
  parameter int NUM_INPUTS = 8   // Receivers, two per pair
) (
  input  wire logic                    pclk,            // APB clock, 100 MHz
  input  wire logic                    presetn,         // Async reset, active low
  input  wire logic                    psel,            // APB select
  input  wire logic                    penable,         // APB enable
  input  wire logic                    pwrite,          // APB direction
  input  wire logic [13:0]             paddr,           // APB byte address
  input  wire logic [31:0]             pwdata,          // APB write data
  input  wire logic [3:0]              pstrb,           // APB byte strobes
  output logic                         pready,          // APB ready
  output logic [31:0]                  prdata,          // APB read data
  output logic                         pslverr,         // APB error
  input  wire logic [3*NUM_INPUTS-1:0] sel_priority,    // Priority per input, 3 bits each
  output logic [NUM_INPUTS-1:0]        rx_powerdown,    // Receiver power-down
  output logic                         rx_deep_sleep,   // Whole section asleep
  output logic [NUM_PAIRS-1:0]         pair_diff,       // Pair differential mode
  output logic [2*NUM_PAIRS-1:0]       pri_family,      // Primary family per pair
  output logic [2*NUM_PAIRS-1:0]       sec_family,      // Effective secondary family
  output logic [NUM_INPUTS-1:0]        manual_en,       // Manual profile per input
  output logic [3*NUM_INPUTS-1:0]      manual_profile,  // Profile per input
  output logic [NUM_INPUTS-1:0]        phase_master     // Phase master per input
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------

  // Word index from byte address; low bits must be zero
  function automatic logic [11:0] word_index(input logic [13:0] addr);
    word_index = addr[13:2];
  endfunction : word_index

  // Priority strictly below threshold means phase master
  function automatic logic is_master(input logic [2:0] prio, input logic [2:0] thr);
    is_master = (prio < thr);
  endfunction : is_master

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  ric_pkg::ric_apb_state_t state_reg, state_next;
  logic [7:0]  powerdown_reg, powerdown_next;
  logic [7:0]  family01_reg, family01_next;
  logic [7:0]  family23_reg, family23_next;
  logic [7:0]  manual_reg [NUM_PAIRS];
  logic [7:0]  manual_next [NUM_PAIRS];
  logic [2:0]  threshold_reg, threshold_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pslverr_reg, pslverr_next;
  logic        deep_sleep_reg, deep_sleep_next;

  logic [11:0] idx;
  logic        hit;
  logic        wr_take;
  logic        rd_take;
  logic [7:0]  rd_byte;
  logic [7:0]  wr_byte;
  logic [15:0] family_all;
  logic        wr_powerdown;
  logic        wr_family01;
  logic        wr_family23;
  logic        wr_threshold;
  logic [NUM_PAIRS-1:0] wr_manual;

  assign idx        = word_index(paddr);
  assign family_all = {family23_reg, family01_reg};

  // Decode of mapped registers; misaligned address counts as unmapped
  always_comb begin
    hit = (paddr[1:0] == 2'h0) &&
          (idx >= `RIC_IDX_POWERDOWN) && (idx <= `RIC_IDX_STATUS);
  end

  // --------------------------------------------------------------------
  // APB phase control
  // --------------------------------------------------------------------

  // Answer in the first access cycle: no wait states
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ric_pkg::RIC_IDLE: begin
        if (psel && !penable) begin
          state_next = ric_pkg::RIC_ACCESS;
        end
      end
      ric_pkg::RIC_ACCESS: begin
        state_next = (psel && !penable) ? ric_pkg::RIC_ACCESS : ric_pkg::RIC_IDLE;
      end
    endcase
  end

  // Phase only qualifies the error output, nothing else depends on it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ric_pkg::RIC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pready  = 1'b1;
  assign wr_take = psel && penable && pwrite && hit && pstrb[0];
  assign rd_take = psel && !penable && !pwrite;
  assign wr_byte = pwdata[7:0];

  // --------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------

  // Unused bits come back as zero by construction
  always_comb begin
    rd_byte = `RIC_RESET_BYTE;
    unique case (idx)
      `RIC_IDX_POWERDOWN: rd_byte = powerdown_reg;
      `RIC_IDX_FAMILY_01: rd_byte = family01_reg;
      `RIC_IDX_FAMILY_23: rd_byte = family23_reg;
      `RIC_IDX_MANUAL_P0: rd_byte = manual_reg[0];
      `RIC_IDX_MANUAL_P1: rd_byte = manual_reg[1];
      `RIC_IDX_MANUAL_P2: rd_byte = manual_reg[2];
      `RIC_IDX_MANUAL_P3: rd_byte = manual_reg[3];
      `RIC_IDX_THRESHOLD: rd_byte = {5'h00, threshold_reg};
      `RIC_IDX_STATUS:    rd_byte = {7'h00, deep_sleep_reg};
      default:            rd_byte = `RIC_RESET_BYTE;
    endcase
  end

  // Read data captured in setup so it is stable through access
  always_comb begin
    prdata_next  = prdata_reg;
    pslverr_next = pslverr_reg;
    if (psel && !penable) begin
      prdata_next  = (rd_take && hit) ? {24'h000000, rd_byte} : 32'h00000000;
      pslverr_next = !hit;
    end
  end

  // Cleared on reset so a stale word never leaks onto the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= `RIC_RESET_WORD;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------

  // One write strobe per register except read-only status, decoded once for the whole bank
  always_comb begin
    wr_powerdown = wr_take && (idx == `RIC_IDX_POWERDOWN);
    wr_family01  = wr_take && (idx == `RIC_IDX_FAMILY_01);
    wr_family23  = wr_take && (idx == `RIC_IDX_FAMILY_23);
    wr_threshold = wr_take && (idx == `RIC_IDX_THRESHOLD);
    for (int p = 0; p < NUM_PAIRS; p++) begin
      wr_manual[p] = wr_take && (idx == (`RIC_IDX_MANUAL_P0 + 12'(p)));
    end
  end

  // --------------------------------------------------------------------
  // Power-down
  // --------------------------------------------------------------------

  // Only byte lane 0 carries data; other lanes are dropped
  always_comb begin
    powerdown_next = powerdown_reg;
    if (wr_powerdown) begin
      powerdown_next = wr_byte;
    end
  end

  // Clears so every receiver starts in normal operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powerdown_reg <= `RIC_RESET_BYTE;
    end else begin
      powerdown_reg <= powerdown_next;
    end
  end

  // Deep sleep only when every receiver is powered down together
  always_comb begin
    deep_sleep_next = (powerdown_reg == `RIC_ALL_DOWN);
  end

  // Registered so the sleep control reaches the receivers glitch-free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deep_sleep_reg <= 1'b0;
    end else begin
      deep_sleep_reg <= deep_sleep_next;
    end
  end

  // --------------------------------------------------------------------
  // Logic family
  // --------------------------------------------------------------------

  // Each byte is taken whole, so a pair never half-switches its mode
  always_comb begin
    family01_next = family01_reg;
    family23_next = family23_reg;
    if (wr_family01) begin
      family01_next = wr_byte;
    end
    if (wr_family23) begin
      family23_next = wr_byte;
    end
  end

  // Code zero: every pair starts as one differential input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      family01_reg <= `RIC_RESET_BYTE;
      family23_reg <= `RIC_RESET_BYTE;
    end else begin
      family01_reg <= family01_next;
      family23_reg <= family23_next;
    end
  end

  // --------------------------------------------------------------------
  // Manual profile
  // --------------------------------------------------------------------

  // One register per pair in consecutive slots
  always_comb begin
    for (int p = 0; p < NUM_PAIRS; p++) begin
      manual_next[p] = manual_reg[p];
      if (wr_manual[p]) begin
        manual_next[p] = wr_byte;
      end
    end
  end

  // Automatic assignment and profile 0 after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
        manual_reg[p] <= `RIC_RESET_BYTE;
      end
    end else begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
        manual_reg[p] <= manual_next[p];
      end
    end
  end

  // --------------------------------------------------------------------
  // Phase master threshold
  // --------------------------------------------------------------------

  // Only three bits are stored; the upper five have no flops at all
  always_comb begin
    threshold_next = threshold_reg;
    if (wr_threshold) begin
      threshold_next = wr_byte[2:0];
    end
  end

  // Zero: no reference is a phase master out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      threshold_reg <= `RIC_THR_RESET;
    end else begin
      threshold_reg <= threshold_next;
    end
  end

  // Error only in the access phase of an unmapped transfer
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg && psel && penable && (state_reg == ric_pkg::RIC_ACCESS);

  // --------------------------------------------------------------------
  // Receiver controls
  // --------------------------------------------------------------------

  // Individual power-downs stay valid even in deep sleep
  assign rx_powerdown  = powerdown_reg;
  assign rx_deep_sleep = deep_sleep_reg;

  // Input order: 2p is pair p primary, 2p+1 its secondary
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    logic [1:0] pri_f;
    logic [1:0] sec_f;
    logic       pri_m;
    logic       sec_m;
    logic [2:0] pri_pr;
    logic [2:0] sec_pr;

    assign pri_f = family_all[p*`RIC_FAM_PAIR_STRIDE + `RIC_FAM_PRI_LSB +: 2];
    assign sec_f = family_all[p*`RIC_FAM_PAIR_STRIDE + `RIC_FAM_SEC_LSB +: 2];

    ric_pair_decode u_dec (
      .pri_family     (pri_f),
      .sec_family     (sec_f),
      .manual_pri     (manual_reg[p][`RIC_MAN_PRI_LSB +: 4]),
      .manual_sec     (manual_reg[p][`RIC_MAN_SEC_LSB +: 4]),
      .pair_diff      (pair_diff[p]),
      .sec_family_eff (sec_family[2*p +: 2]),
      .pri_manual     (pri_m),
      .pri_profile    (pri_pr),
      .sec_manual     (sec_m),
      .sec_profile    (sec_pr)
    );

    assign pri_family[2*p +: 2]           = pri_f;
    assign manual_en[2*p]                 = pri_m;
    assign manual_en[2*p+1]               = sec_m;
    assign manual_profile[6*p +: 3]       = pri_pr;
    assign manual_profile[6*p+3 +: 3]     = sec_pr;
  end

  // Phase master flags from each input's selection priority
  for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_master
    assign phase_master[i] = is_master(sel_priority[3*i +: 3], threshold_reg);
  end

endmodule : ric_regs

// ---- inc/ric_defines.svh ----
// Constants for the reference input configuration register bank
`ifndef RIC_DEFINES_SVH
`define RIC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define RIC_IDX_POWERDOWN   12'h500
`define RIC_IDX_FAMILY_01   12'h501
`define RIC_IDX_FAMILY_23   12'h502
`define RIC_IDX_MANUAL_P0   12'h503
`define RIC_IDX_MANUAL_P1   12'h504
`define RIC_IDX_MANUAL_P2   12'h505
`define RIC_IDX_MANUAL_P3   12'h506
`define RIC_IDX_THRESHOLD   12'h507
`define RIC_IDX_STATUS      12'h508

// ----------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------
`define RIC_RESET_BYTE      8'h00
`define RIC_ALL_DOWN        8'hff
`define RIC_FAM_PRI_LSB     0
`define RIC_FAM_SEC_LSB     2
`define RIC_FAM_PAIR_STRIDE 4
`define RIC_MAN_PRI_LSB     0
`define RIC_MAN_SEC_LSB     4
`define RIC_MAN_EN_OFS      3
`define RIC_THR_MASK        8'h07
`define RIC_FAM_DIFF        2'h0
`define RIC_THR_RESET       3'h0
`define RIC_RESET_WORD      32'h00000000

`endif

// ---- inc/ric_pkg.sv ----
// Types for the reference input configuration register bank
package ric_pkg;

  // Receiver family codes
  typedef enum logic [1:0] {
    RIC_FAM_OFF_OR_DIFF = 2'h0,
    RIC_FAM_CMOS_12     = 2'h1,
    RIC_FAM_CMOS_18     = 2'h2,
    RIC_FAM_CMOS_30     = 2'h3
  } ric_family_t;

  // APB slave phases
  typedef enum logic [0:0] {
    RIC_IDLE,
    RIC_ACCESS
  } ric_apb_state_t;

endpackage : ric_pkg

// ---- hw/ric_pair_decode.sv ----
// Per-pair receiver mode and profile decode
`include "ric_defines.svh"

module ric_pair_decode (
  input  wire logic [1:0] pri_family,      // Primary family field
  input  wire logic [1:0] sec_family,      // Secondary family field
  input  wire logic [3:0] manual_pri,      // Primary enable and profile
  input  wire logic [3:0] manual_sec,      // Secondary enable and profile
  output logic            pair_diff,       // Pair runs as one differential input
  output logic [1:0]      sec_family_eff,  // Secondary family after masking
  output logic            pri_manual,      // Primary uses manual profile
  output logic [2:0]      pri_profile,     // Primary manual profile
  output logic            sec_manual,      // Secondary uses manual profile
  output logic [2:0]      sec_profile      // Secondary manual profile
);

  // Secondary field is meaningless in differential mode, so force disabled
  always_comb begin
    pair_diff      = (pri_family == `RIC_FAM_DIFF);
    sec_family_eff = pair_diff ? `RIC_FAM_DIFF : sec_family;
    pri_manual     = manual_pri[`RIC_MAN_EN_OFS];
    pri_profile    = manual_pri[2:0];
    sec_manual     = manual_sec[`RIC_MAN_EN_OFS];
    sec_profile    = manual_sec[2:0];
  end

endmodule : ric_pair_decode

// ---- dv/ric_regs_checker.sv ----
// Checker bound to the reference input configuration register bank
module ric_regs_checker #(
  parameter int NUM_PAIRS  = 4,  // Pairs
  parameter int NUM_INPUTS = 8   // Inputs
) (
  input wire logic                    pclk,           // Clock
  input wire logic                    presetn,        // Reset
  input wire logic                    psel,           // Select
  input wire logic                    penable,        // Enable
  input wire logic                    pwrite,         // Direction
  input wire logic [13:0]             paddr,          // Address
  input wire logic [31:0]             pwdata,         // Write data
  input wire logic [3:0]              pstrb,          // Strobes
  input wire logic                    pready,         // Ready
  input wire logic [31:0]             prdata,         // Read data
  input wire logic                    pslverr,        // Error
  input wire logic [3*NUM_INPUTS-1:0] sel_priority,   // Priorities
  input wire logic [NUM_INPUTS-1:0]   rx_powerdown,   // Power-down
  input wire logic                    rx_deep_sleep,  // Deep sleep
  input wire logic [NUM_PAIRS-1:0]    pair_diff,      // Differential
  input wire logic [2*NUM_PAIRS-1:0]  pri_family,     // Primary family
  input wire logic [2*NUM_PAIRS-1:0]  sec_family,     // Secondary family
  input wire logic [NUM_INPUTS-1:0]   manual_en,      // Manual enable
  input wire logic [3*NUM_INPUTS-1:0] manual_profile, // Profiles
  input wire logic [NUM_INPUTS-1:0]   phase_master    // Phase masters
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Transfer decode
  // ----------------------------------------
  logic acc;
  logic wr_ok;
  logic mapped;
  assign acc    = psel && penable;
  assign wr_ok  = acc && pwrite && pready && pstrb[0];
  assign mapped = paddr[1:0] == 2'h0 && paddr[13:2] >= 12'h500 && paddr[13:2] <= 12'h508;
  a_deep_sleep_follow: assert property (1'b1 |=> rx_deep_sleep == ($past(rx_powerdown) == 8'hff))
    else $error("deep sleep wrong");
  a_pd_write_lands: assert property (wr_ok && paddr == 14'h1400 |=> rx_powerdown == $past(pwdata[7:0]))
    else $error("power-down write lost");
  a_pd_holds: assert property (!(wr_ok && paddr == 14'h1400) |=> $stable(rx_powerdown))
    else $error("power-down changed");
  a_diff_decode: assert property (pair_diff == {pri_family[7:6] == 2'h0, pri_family[5:4] == 2'h0,
    pri_family[3:2] == 2'h0, pri_family[1:0] == 2'h0}) else $error("diff decode");
  a_sec_masked: assert property ((sec_family & {{2{pair_diff[3]}}, {2{pair_diff[2]}},
    {2{pair_diff[1]}}, {2{pair_diff[0]}}}) == 8'h00) else $error("secondary not masked");
  a_fam_write: assert property (wr_ok && paddr == 14'h1404
    |=> pri_family[3:0] == {$past(pwdata[5:4]), $past(pwdata[1:0])}) else $error("family");
  a_manual_write: assert property (wr_ok && paddr == 14'h140c |=> manual_en[1:0] ==
    {$past(pwdata[7]), $past(pwdata[3])} && manual_profile[5:0] ==
    {$past(pwdata[6:4]), $past(pwdata[2:0])}) else $error("manual profile");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access");
  a_read_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits");
  a_master_order: assert property (sel_priority[2:0] <= sel_priority[5:3] && phase_master[1]
    |-> phase_master[0]) else $error("phase master order");
  a_lowest_never: assert property (sel_priority[23:21] == 3'h7 |-> !phase_master[7])
    else $error("priority 7 master");
endmodule : ric_regs_checker

bind ric_regs ric_regs_checker #(.NUM_PAIRS(NUM_PAIRS), .NUM_INPUTS(NUM_INPUTS)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .sel_priority(sel_priority), .rx_powerdown(rx_powerdown),
  .rx_deep_sleep(rx_deep_sleep), .pair_diff(pair_diff), .pri_family(pri_family),
  .sec_family(sec_family), .manual_en(manual_en), .manual_profile(manual_profile),
  .phase_master(phase_master));

// ---- dv/tb_top.sv ----
// Testbench for the reference input configuration register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_deep_sleep, rerr;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb, pair_diff;
  logic [23:0] sel_priority, manual_profile;
  logic [7:0]  rx_powerdown, pri_family, sec_family, manual_en, phase_master;
  int          mismatches, n_checks;
  ric_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .sel_priority(sel_priority),
    .rx_powerdown(rx_powerdown), .rx_deep_sleep(rx_deep_sleep), .pair_diff(pair_diff),
    .pri_family(pri_family), .sec_family(sec_family), .manual_en(manual_en),
    .manual_profile(manual_profile), .phase_master(phase_master));
  // Free-running 100 MHz clock
  always #5 pclk = ~pclk;
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic end_of_test();
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Holds the request until pready; the bound cuts a hung slave short
  task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
  endtask : apb
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    apb(1'b1, {idx, 2'b00}, {24'h0, d}, 4'hf);
  endtask : wr
  task automatic rdc(input logic [13:0] a, input logic [7:0] exp, input logic err);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rdat, {24'h0, exp});
    chk({31'h0, rerr}, {31'h0, err});
  endtask : rdc
  task automatic settle();
    @(posedge pclk); #1;
  endtask : settle
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    pstrb = 0;
    sel_priority = 24'hfac688;
    mismatches = 0;
    n_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk(pair_diff, 4'hf);
    for (int k = 0; k < 8; k++) rdc({12'h500 + 12'(k), 2'b00}, 8'h00, 1'b0);
    // Pattern per register; threshold keeps only its low three bits
    for (int k = 0; k < 8; k++) wr(12'h500 + 12'(k), 8'h96 + 8'(k));
    for (int k = 0; k < 8; k++) rdc({12'h500 + 12'(k), 2'b00}, k == 7 ? 8'h05 : 8'h96 + 8'(k), 1'b0);
    apb(1'b1, 14'h1400, 32'hff, 4'h0);
    rdc(14'h1400, 8'h96, 1'b0);
    rdc(14'h1424, 8'h00, 1'b1);
    rdc(14'h1401, 8'h00, 1'b1);
    apb(1'b1, 14'h1424, 32'hff, 4'hf);
    chk({31'h0, rerr}, 32'h1);
    wr(12'h500, 8'hff);
    settle();
    chk(rx_deep_sleep, 1'b1);
    rdc(14'h1420, 8'h01, 1'b0);
    wr(12'h500, 8'h7f);
    settle();
    chk(rx_deep_sleep, 1'b0);
    chk(rx_powerdown, 8'h7f);
    // Status is read-only: a write neither lands nor disturbs power-down
    wr(12'h508, 8'hff);
    rdc(14'h1420, 8'h00, 1'b0);
    rdc(14'h1400, 8'h7f, 1'b0);
    // Every family code on both registers; secondary must vanish on code 0
    for (int c = 0; c < 4; c++) begin
      wr(12'h501, {2'(3 - c), 2'(c), 2'(3 - c), 2'(c)});
      wr(12'h502, {2'(3 - c), 2'(c), 2'(3 - c), 2'(c)});
      settle();
      chk(pri_family, {4{2'(c)}});
      chk(pair_diff, c == 0 ? 4'hf : 4'h0);
      chk(sec_family, c == 0 ? 8'h00 : {4{2'(3 - c)}});
    end
    for (int p = 0; p < 4; p++) wr(12'h503 + 12'(p), {1'b1, 3'(2 * p + 1), 1'b0, 3'(2 * p)});
    settle();
    chk(manual_en, 8'haa);
    chk(manual_profile, 24'hfac688);
    for (int t = 0; t < 8; t++) begin
      wr(12'h507, 8'(t));
      settle();
      chk(phase_master, 8'((1 << t) - 1));
    end
    // Reversed priorities: input 0 now ranks lowest and loses mastership
    @(posedge pclk);
    sel_priority <= 24'h053977;
    settle();
    chk(phase_master, 8'hfe);
    // Reset in mid-run clears every register again
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 8; k++) rdc({12'h500 + 12'(k), 2'b00}, 8'h00, 1'b0);
    chk(pair_diff, 4'hf);
    chk(phase_master, 8'h00);
    end_of_test();
  end
endmodule : tb_top
